/* File: rtl/fdd_override_ring_pkg.sv */
/*
  Shared constants for the floppy override and ring filter register bank:
  register indices, field positions, reset values and ring timing.
  Assumes a 100 MHz pclk; byte address of a register is four times its index.
*/
package fdd_override_ring_pkg;

  // Register indices; byte address = index * 4
  localparam logic [9:0] IDX_DISK_CHANGE_OVERRIDE = 10'h0c1;
  localparam logic [9:0] IDX_FLOPPY_RATE_MIRROR = 10'h0c2;
  localparam logic [9:0] IDX_SERIAL_A_FIFO_CTL_MIRROR = 10'h0c3;
  localparam logic [9:0] IDX_SERIAL_B_FIFO_CTL_MIRROR = 10'h0c4;
  localparam logic [9:0] IDX_WRITE_PROTECT_OVERRIDE = 10'h0c5;
  localparam logic [9:0] IDX_RING_FILTER_SELECT = 10'h0c6;
  localparam logic [9:0] IDX_EVENT_STATUS = 10'h0c7;
  localparam logic [9:0] IDX_EVENT_CLEAR = 10'h0c8;
  localparam logic [9:0] IDX_EVENT_ENABLE = 10'h0c9;

  // Reset values
  localparam logic [1:0] RST_DISK_CHANGE_OVERRIDE = 2'h3;
  localparam logic [0:0] RST_WRITE_PROTECT_OVERRIDE = 1'h0;
  localparam logic [2:0] RST_RING_FILTER_SELECT = 3'h0;
  localparam logic [4:0] RST_EVENT_ENABLE = 5'h00;

  // Field widths and positions
  localparam int FORCE_CHANGE_W = 2;
  localparam int RING_CH = 3;
  localparam int EVENT_W = 5;
  localparam int EV_RING_WAKE = 0;
  localparam int EV_RING_A = 1;
  localparam int EV_RING_B = 2;
  localparam int EV_CHANGE0_CLEARED = 3;
  localparam int EV_CHANGE1_CLEARED = 4;
  localparam int RATE_RESERVED_BIT = 5;
  localparam int FIFO_RESERVED_LO = 4;
  localparam int FIFO_RESERVED_HI = 5;

  // Ring pulse-train timing
  localparam longint CLK_HZ = 100000000;
  localparam longint RING_MIN_FREQ_HZ = 15;
  localparam longint RING_TRAIN_MS = 200;
  localparam int RING_CNT_W = 25;
  // Longest edge spacing still inside a train: round down
  localparam logic [24:0] RING_GAP_CYCLES = 25'(CLK_HZ / RING_MIN_FREQ_HZ);
  // Least train length before the ring output goes low: round up
  localparam logic [24:0] RING_TRAIN_CYCLES = 25'((RING_TRAIN_MS * CLK_HZ + 999) / 1000);

endpackage

/* File: rtl/fdd_override_ring_regs.sv */
/*
  Floppy disk-change and write-protect override registers, read-only mirrors
  of the floppy rate and serial FIFO control registers, the ring-indicator
  filter and a small event/interrupt block, all behind an APB slave.
  Assumes mirrored sources are on pclk; floppy and ring pins are asynchronous.
*/
`timescale 1ns/10ps

module fdd_override_ring_regs #(
  parameter logic [24:0] RING_GAP_CYCLES = fdd_override_ring_pkg::RING_GAP_CYCLES,
  parameter logic [24:0] RING_TRAIN_CYCLES = fdd_override_ring_pkg::RING_TRAIN_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Floppy drive interface pins
  input wire logic step_strobe_n,
  input wire logic drive0_select_n,
  input wire logic drive1_select_n,
  input wire logic disk_change_in_n,
  input wire logic write_protect_in_n,
  input wire logic pp_write_protect_in_n,
  // Toward the floppy core
  output logic disk_changed_flag,
  output logic write_protect_core_n,
  output logic pp_write_protect_core_n,
  // Mirrored source registers
  input wire logic [7:0] floppy_rate_src,
  input wire logic [7:0] serial_a_fifo_ctl_src,
  input wire logic [7:0] serial_b_fifo_ctl_src,
  // Ring pins and ring indications
  input wire logic ring_wake_in_n,
  input wire logic ring_ind_a_n,
  input wire logic ring_ind_b_n,
  output logic ring_wake_out_n,
  output logic ring_a_out_n,
  output logic ring_b_out_n,
  // Interrupt
  output logic irq
);

  localparam int PIN_W = 9;

  // Synchronised pins
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  logic [PIN_W-1:0] pin_prev_reg;

  assign pin_raw = {ring_ind_b_n, ring_ind_a_n, ring_wake_in_n, pp_write_protect_in_n,
                    write_protect_in_n, disk_change_in_n, drive1_select_n,
                    drive0_select_n, step_strobe_n};

  // Two stages per pin; a third stage keeps the previous value for edge detection
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++)
    begin : gen_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_reg[g] <= 1'b1;
          sync2_reg[g] <= 1'b1;
          pin_prev_reg[g] <= 1'b1;
        end
        else
        begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          pin_prev_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate

  logic step_s_n;
  logic ds0_s_n;
  logic ds1_s_n;
  logic dskchg_s_n;
  logic wp_s_n;
  logic pp_wp_s_n;
  logic [2:0] ring_s_n;
  logic [2:0] ring_prev_n;
  logic step_fall;

  assign step_s_n = sync2_reg[0];
  assign ds0_s_n = sync2_reg[1];
  assign ds1_s_n = sync2_reg[2];
  assign dskchg_s_n = sync2_reg[3];
  assign wp_s_n = sync2_reg[4];
  assign pp_wp_s_n = sync2_reg[5];
  assign ring_s_n = sync2_reg[8:6];
  assign ring_prev_n = pin_prev_reg[8:6];
  assign step_fall = pin_prev_reg[0] & ~step_s_n;

  // APB decode
  logic [1:0] force_change_reg;
  logic [0:0] wp_force_reg;
  logic [2:0] ring_sel_reg;
  logic [4:0] ev_status_reg;
  logic [4:0] ev_enable_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [9:0] idx;
  logic aligned;
  logic setup_phase;
  logic wr_commit;
  logic hit_dco;
  logic hit_rate;
  logic hit_sa;
  logic hit_sb;
  logic hit_wp;
  logic hit_ring;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic mapped;
  logic [7:0] rate_view;
  logic [7:0] sa_view;
  logic [7:0] sb_view;
  logic [7:0] rd_sel;

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup_phase = psel & ~penable;
  assign hit_dco = aligned & (idx == fdd_override_ring_pkg::IDX_DISK_CHANGE_OVERRIDE);
  assign hit_rate = aligned & (idx == fdd_override_ring_pkg::IDX_FLOPPY_RATE_MIRROR);
  assign hit_sa = aligned & (idx == fdd_override_ring_pkg::IDX_SERIAL_A_FIFO_CTL_MIRROR);
  assign hit_sb = aligned & (idx == fdd_override_ring_pkg::IDX_SERIAL_B_FIFO_CTL_MIRROR);
  assign hit_wp = aligned & (idx == fdd_override_ring_pkg::IDX_WRITE_PROTECT_OVERRIDE);
  assign hit_ring = aligned & (idx == fdd_override_ring_pkg::IDX_RING_FILTER_SELECT);
  assign hit_stat = aligned & (idx == fdd_override_ring_pkg::IDX_EVENT_STATUS);
  assign hit_clr = aligned & (idx == fdd_override_ring_pkg::IDX_EVENT_CLEAR);
  assign hit_en = aligned & (idx == fdd_override_ring_pkg::IDX_EVENT_ENABLE);
  assign mapped = hit_dco | hit_rate | hit_sa | hit_sb | hit_wp | hit_ring | hit_stat
                  | hit_clr | hit_en;
  // Writes land only in the access cycle that completes, and only if mapped
  assign wr_commit = psel & penable & pready_reg & pwrite & mapped;

  // Mirrors are plain views of the sources with reserved bits masked
  assign rate_view = floppy_rate_src & ~(8'h01 << fdd_override_ring_pkg::RATE_RESERVED_BIT);
  assign sa_view = {serial_a_fifo_ctl_src[7:6], 2'h0, serial_a_fifo_ctl_src[3:0]};
  assign sb_view = {serial_b_fifo_ctl_src[7:6], 2'h0, serial_b_fifo_ctl_src[3:0]};

  assign rd_sel = hit_dco ? {6'h00, force_change_reg} :
                  hit_rate ? rate_view :
                  hit_sa ? sa_view :
                  hit_sb ? sb_view :
                  hit_wp ? {7'h00, wp_force_reg} :
                  hit_ring ? {5'h00, ring_sel_reg} :
                  hit_stat ? {3'h0, ev_status_reg} :
                  hit_en ? {3'h0, ev_enable_reg} :
                  8'h00;

  // One registered ready: setup cycle, then a single access cycle
  // Read data is latched in the setup cycle, so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~mapped;
      if (setup_phase)
      begin
        prdata_reg <= pwrite ? 32'h00000000 : {24'h000000, rd_sel};
      end
    end
  end

  // Forced disk change bits
  logic [1:0] change_clr;
  logic [1:0] change_set;
  logic [1:0] force_change_next;

  // A step strobe counts once, on its synchronised falling edge
  assign change_clr[0] = step_fall & ~ds0_s_n;
  assign change_clr[1] = step_fall & ~ds1_s_n;
  assign change_set = (wr_commit & hit_dco) ? pwdata[1:0] : 2'h0;
  // Software only ORs ones in; a hardware clear loses to a same-cycle set
  assign force_change_next = (force_change_reg & ~change_clr) | change_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      force_change_reg <= fdd_override_ring_pkg::RST_DISK_CHANGE_OVERRIDE;
      wp_force_reg <= fdd_override_ring_pkg::RST_WRITE_PROTECT_OVERRIDE;
      ring_sel_reg <= fdd_override_ring_pkg::RST_RING_FILTER_SELECT;
      ev_enable_reg <= fdd_override_ring_pkg::RST_EVENT_ENABLE;
    end
    else
    begin
      force_change_reg <= force_change_next;
      if (wr_commit & hit_wp)
      begin
        wp_force_reg <= pwdata[0:0];
      end
      if (wr_commit & hit_ring)
      begin
        ring_sel_reg <= pwdata[2:0];
      end
      if (wr_commit & hit_en)
      begin
        ev_enable_reg <= pwdata[4:0];
      end
    end
  end

  // Signals toward the floppy core, registered
  logic disk_changed_flag_next;
  logic wp_core_next;
  logic pp_wp_core_next;

  // The force terms gate with the high level of the select lines; users must
  // expect the forced indication only while that select is high
  assign disk_changed_flag_next = (ds0_s_n & force_change_reg[0]) | (ds1_s_n & force_change_reg[1])
                        | dskchg_s_n;
  assign wp_core_next = (ds0_s_n & wp_force_reg[0]) | wp_s_n;
  assign pp_wp_core_next = (ds0_s_n & wp_force_reg[0]) | pp_wp_s_n;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disk_changed_flag <= 1'b1;
      write_protect_core_n <= 1'b1;
      pp_write_protect_core_n <= 1'b1;
    end
    else
    begin
      disk_changed_flag <= disk_changed_flag_next;
      write_protect_core_n <= wp_core_next;
      pp_write_protect_core_n <= pp_wp_core_next;
    end
  end

  // Ring filter, one channel per ring pin
  // Trains are timed in both modes, so a switch to filtered mode mid-train counts it
  logic [2:0] ring_out_reg;
  logic [2:0] ring_out_next;
  logic [2:0] ring_event;

  generate
    for (g = 0; g < fdd_override_ring_pkg::RING_CH; g++)
    begin : gen_ring
      logic fall;
      logic in_train_reg;
      logic [24:0] gap_cnt_reg;
      logic [24:0] dur_cnt_reg;
      logic gap_over;
      logic qualified;

      assign fall = ring_prev_n[g] & ~ring_s_n[g];
      // Counters stop at their limits, so a long train cannot wrap them
      assign gap_over = (gap_cnt_reg >= RING_GAP_CYCLES - 25'h0000001);
      assign qualified = in_train_reg & (dur_cnt_reg >= RING_TRAIN_CYCLES);
      // Filtered: low while a qualified train runs; else follow the pin
      assign ring_out_next[g] = ring_sel_reg[g] ? ~qualified : ring_s_n[g];
      // Leading falling edge of the output is the ring indication
      assign ring_event[g] = ring_out_reg[g] & ~ring_out_next[g];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          in_train_reg <= 1'b0;
          gap_cnt_reg <= 25'h0000000;
          dur_cnt_reg <= 25'h0000000;
          ring_out_reg[g] <= 1'b1;
        end
        else
        begin
          ring_out_reg[g] <= ring_out_next[g];
          if (fall)
          begin
            // Each falling edge restarts the gap window and keeps the train alive
            in_train_reg <= 1'b1;
            gap_cnt_reg <= 25'h0000000;
          end
          else if (in_train_reg & gap_over)
          begin
            in_train_reg <= 1'b0;
          end
          else if (in_train_reg)
          begin
            gap_cnt_reg <= gap_cnt_reg + 25'h0000001;
          end
          if (!in_train_reg)
          begin
            dur_cnt_reg <= 25'h0000000;
          end
          else if (dur_cnt_reg < RING_TRAIN_CYCLES)
          begin
            dur_cnt_reg <= dur_cnt_reg + 25'h0000001;
          end
        end
      end
    end
  endgenerate

  // Events: sticky status, write-one-to-clear, enable mask; set wins
  logic [4:0] ev_in;
  logic [4:0] ev_clr;
  logic [4:0] ev_status_next;

  assign ev_in[fdd_override_ring_pkg::EV_RING_WAKE] = ring_event[0];
  assign ev_in[fdd_override_ring_pkg::EV_RING_A] = ring_event[1];
  assign ev_in[fdd_override_ring_pkg::EV_RING_B] = ring_event[2];
  assign ev_in[fdd_override_ring_pkg::EV_CHANGE0_CLEARED] = change_clr[0] & force_change_reg[0];
  assign ev_in[fdd_override_ring_pkg::EV_CHANGE1_CLEARED] = change_clr[1] & force_change_reg[1];
  assign ev_clr = (wr_commit & hit_clr) ? pwdata[4:0] : 5'h00;
  assign ev_status_next = (ev_status_reg & ~ev_clr) | ev_in;
  // The interrupt follows status and enable one cycle later

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_status_reg <= 5'h00;
      irq <= 1'b0;
    end
    else
    begin
      ev_status_reg <= ev_status_next;
      irq <= |(ev_status_reg & ev_enable_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ring_wake_out_n = ring_out_reg[0];
  assign ring_a_out_n = ring_out_reg[1];
  assign ring_b_out_n = ring_out_reg[2];

endmodule

/* File: tb/fdd_override_ring_asserts.sv */
/*
  Checker for the override and ring register bank: APB answer, pin paths, ring pass-through.
  Assumes it is bound to the bank's top module and sees only its ports.
*/
`timescale 1ns/10ps
module fdd_override_ring_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic drive0_select_n,
  input wire logic disk_change_in_n,
  input wire logic write_protect_in_n,
  input wire logic pp_write_protect_in_n,
  input wire logic ring_wake_in_n,
  input wire logic ring_ind_a_n,
  // Outputs
  input wire logic disk_changed_flag,
  input wire logic write_protect_core_n,
  input wire logic pp_write_protect_core_n,
  input wire logic ring_wake_out_n,
  input wire logic ring_a_out_n,
  input wire logic irq
);
  logic [2:0] up_reg;
  logic [1:0] rsel_reg;
  wire up = (up_reg == 3'h7);
  wire rsel_wr = psel && penable && pready && pwrite && !pslverr && (paddr == 12'h318);
  // Pin history is only trusted a few cycles after reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up_reg <= 3'h0;
    else if (!up)
      up_reg <= up_reg + 3'h1;
  // Shadow of the wake and ring A mode bits taken from APB writes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rsel_reg <= 2'h0;
    else if (rsel_wr)
      rsel_reg <= pwdata[1:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  high_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chg_input_a: assert property (up && $past(disk_change_in_n, 3) |-> disk_changed_flag)
    else $error("disk change flag low with change input high");
  wp_select_a: assert property (up && !$past(drive0_select_n, 3)
    |-> write_protect_core_n == $past(write_protect_in_n, 3))
    else $error("core write protect wrong while drive 0 selected");
  pp_select_a: assert property (up && !$past(drive0_select_n, 3)
    |-> pp_write_protect_core_n == $past(pp_write_protect_in_n, 3))
    else $error("parallel write protect wrong while drive 0 selected");
  wake_direct_a: assert property (up && !rsel_reg[0] && !$past(rsel_reg[0], 3)
    |-> ring_wake_out_n == $past(ring_wake_in_n, 3))
    else $error("unfiltered wake output does not follow pin");
  ring_a_direct_a: assert property (up && !rsel_reg[1] && !$past(rsel_reg[1], 3)
    |-> ring_a_out_n == $past(ring_ind_a_n, 3))
    else $error("unfiltered ring A output does not follow pin");
  cover property (pready && pslverr);
  cover property (rsel_reg[0] && !ring_wake_out_n);
  cover property (irq);
endmodule

bind fdd_override_ring_regs fdd_override_ring_asserts chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive0_select_n(drive0_select_n),
  .disk_change_in_n(disk_change_in_n), .write_protect_in_n(write_protect_in_n),
  .pp_write_protect_in_n(pp_write_protect_in_n), .ring_wake_in_n(ring_wake_in_n),
  .ring_ind_a_n(ring_ind_a_n), .disk_changed_flag(disk_changed_flag),
  .write_protect_core_n(write_protect_core_n), .pp_write_protect_core_n(pp_write_protect_core_n),
  .ring_wake_out_n(ring_wake_out_n), .ring_a_out_n(ring_a_out_n), .irq(irq));

/* File: tb/fdd_drive_model.sv */
/*
  Model of the floppy drive pins and the three modem ring lines.
  Assumes the bench calls its tasks; all pins idle high, changed after rising edges.
*/
`timescale 1ns/10ps
module fdd_drive_model (
  // Clock
  input wire logic pclk,
  // Drive pins
  output logic step_strobe_n = 1'b1,
  output logic drive0_select_n = 1'b1,
  output logic drive1_select_n = 1'b1,
  output logic disk_change_in_n = 1'b1,
  output logic write_protect_in_n = 1'b1,
  output logic pp_write_protect_in_n = 1'b1,
  // Ring pins
  output logic ring_wake_in_n,
  output logic ring_ind_a_n,
  output logic ring_ind_b_n
);
  logic [2:0] ring_q = 3'h7;
  assign {ring_ind_b_n, ring_ind_a_n, ring_wake_in_n} = ring_q;
  task automatic set_pins(input logic d0, input logic d1, input logic c, input logic w,
                          input logic pw);
    @(posedge pclk);
    drive0_select_n <= d0;
    drive1_select_n <= d1;
    disk_change_in_n <= c;
    write_protect_in_n <= w;
    pp_write_protect_in_n <= pw;
  endtask
  // One step pulse with the given drive selected
  task automatic step(input int drv);
    @(posedge pclk);
    if (drv == 0)
      drive0_select_n <= 1'b0;
    else
      drive1_select_n <= 1'b0;
    repeat (3) @(posedge pclk);
    step_strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
    step_strobe_n <= 1'b1;
    repeat (3) @(posedge pclk);
    drive0_select_n <= 1'b1;
    drive1_select_n <= 1'b1;
  endtask
  // n low pulses on one ring line, period 2*half cycles
  task automatic ring_burst(input int ch, input int n, input int half);
    repeat (n)
    begin
      @(posedge pclk);
      ring_q[ch] <= 1'b0;
      repeat (half) @(posedge pclk);
      ring_q[ch] <= 1'b1;
      repeat (half - 1) @(posedge pclk);
    end
  endtask
endmodule

/* File: tb/tb.sv */
/*
  Self-checking bench: APB register tests, floppy overrides, interrupts, ring filter.
  Assumes short ring timing parameters (gap 20, train 100 cycles).
*/
`timescale 1ns/10ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, prv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, irq, disk_changed_flag, write_protect_core_n, pp_write_protect_core_n;
  logic step_strobe_n, drive0_select_n, drive1_select_n, disk_change_in_n;
  logic write_protect_in_n, pp_write_protect_in_n, ring_wake_in_n, ring_ind_a_n, ring_ind_b_n;
  logic ring_wake_out_n, ring_a_out_n, ring_b_out_n;
  logic [7:0] floppy_rate_src = 8'hff, serial_a_fifo_ctl_src = 8'hff, serial_b_fifo_ctl_src = 8'h5a;
  wire [2:0] ring_outs = {ring_b_out_n, ring_a_out_n, ring_wake_out_n};
  int error_cnt = 0, n_checks = 0, lo_n, falls;
  always #5 pclk = ~pclk;
  fdd_override_ring_regs #(.RING_GAP_CYCLES(25'd20), .RING_TRAIN_CYCLES(25'd100)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_strobe_n(step_strobe_n), .drive0_select_n(drive0_select_n),
    .drive1_select_n(drive1_select_n), .disk_change_in_n(disk_change_in_n),
    .write_protect_in_n(write_protect_in_n), .pp_write_protect_in_n(pp_write_protect_in_n),
    .disk_changed_flag(disk_changed_flag), .write_protect_core_n(write_protect_core_n),
    .pp_write_protect_core_n(pp_write_protect_core_n), .floppy_rate_src(floppy_rate_src),
    .serial_a_fifo_ctl_src(serial_a_fifo_ctl_src), .serial_b_fifo_ctl_src(serial_b_fifo_ctl_src),
    .ring_wake_in_n(ring_wake_in_n), .ring_ind_a_n(ring_ind_a_n), .ring_ind_b_n(ring_ind_b_n),
    .ring_wake_out_n(ring_wake_out_n), .ring_a_out_n(ring_a_out_n), .ring_b_out_n(ring_b_out_n),
    .irq(irq));
  fdd_drive_model fm (.pclk(pclk), .step_strobe_n(step_strobe_n),
    .drive0_select_n(drive0_select_n), .drive1_select_n(drive1_select_n),
    .disk_change_in_n(disk_change_in_n), .write_protect_in_n(write_protect_in_n),
    .pp_write_protect_in_n(pp_write_protect_in_n), .ring_wake_in_n(ring_wake_in_n),
    .ring_ind_a_n(ring_ind_a_n), .ring_ind_b_n(ring_ind_b_n));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    check(n < 50, 1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(0, a, 0);
    check(q, exp);
    check(e, err);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    $display("[ERR] %0t: watchdog expired", $time);
    test_done;
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(12'h304, 32'h3, 0);
    rd(12'h314, 32'h0, 0);
    rd(12'h318, 32'h0, 0);
    rd(12'h324, 32'h0, 0);
    $display("test reset values done");
    rd(12'h308, 32'hdf, 0);
    rd(12'h30c, 32'hcf, 0);
    rd(12'h310, 32'h4a, 0);
    apb(1, 12'h30c, 32'h0);
    serial_a_fifo_ctl_src <= 8'h3c;
    rd(12'h30c, 32'h0c, 0);
    rd(12'h3fc, 32'h0, 1);
    rd(12'h305, 32'h0, 1);
    $display("test mirrors and refusals done");
    fm.set_pins(1, 1, 0, 0, 0);
    apb(1, 12'h304, 32'h0);
    rd(12'h304, 32'h3, 0);
    settle(4);
    check(disk_changed_flag, 1);
    fm.step(0);
    rd(12'h304, 32'h2, 0);
    rd(12'h31c, 32'h8, 0);
    check(irq, 0);
    apb(1, 12'h324, 32'h8);
    settle(2);
    check(irq, 1);
    apb(1, 12'h320, 32'h8);
    settle(2);
    check(irq, 0);
    rd(12'h31c, 32'h0, 0);
    fm.step(1);
    rd(12'h304, 32'h0, 0);
    settle(4);
    check(disk_changed_flag, 0);
    apb(1, 12'h304, 32'hff);
    rd(12'h304, 32'h3, 0);
    $display("test disk change and interrupt done");
    apb(1, 12'h314, 32'hff);
    rd(12'h314, 32'h1, 0);
    settle(4);
    check(write_protect_core_n, 1);
    check(pp_write_protect_core_n, 1);
    apb(1, 12'h314, 32'h0);
    settle(4);
    check(write_protect_core_n, 0);
    $display("test write protect done");
    for (int ch = 0; ch < 3; ch++)
    begin
      apb(1, 12'h320, 32'h1f);
      fm.ring_burst(ch, 1, 4);
      settle(4);
      rd(12'h31c, 32'h1 << ch, 0);
    end
    apb(1, 12'h318, 32'h7);
    rd(12'h318, 32'h7, 0);
    for (int ch = 0; ch < 3; ch++)
    begin
      apb(1, 12'h320, 32'h1f);
      fm.ring_burst(ch, 6, 4);
      settle(30);
      rd(12'h31c, 32'h0, 0);
      lo_n = 0;
      falls = 0;
      prv = 1'b1;
      fork
        fm.ring_burst(ch, 30, 4);
        repeat (300)
        begin
          @(negedge pclk);
          if (ring_outs[ch] === 1'b0)
            lo_n++;
          if (ring_outs[ch] === 1'b0 && prv === 1'b1)
            falls++;
          prv = ring_outs[ch];
        end
      join
      check(lo_n >= 132, 1);
      check(ring_outs[ch], 1);
      check(falls, 1);
      rd(12'h31c, 32'h1 << ch, 0);
    end
    $display("test ring filter done");
    test_done;
  end
endmodule
